// file: hdl/pmx_mux.sv
// Function
// - shared pins feed port and peripheral input together
// - and pins drive port bit and peripheral
// - or pins drive port bit or peripheral
// - selector bit picks port or alternate output
// - standby holds pins; reset gives hi-z
// - port 0 carries nmi and four irqs
// - port 1 serial0, async rx/tx combining
// - port 2 timer g and byte timers
// - port 3 clock out, timer c, bit5 plain
// - port 8 serial1 and can combining
// - lcd common and segments on selector ports
// - port 7 input-only, analog channels
// - port 10 output-only meter channels 1, 2
// - port 11 meters 3,4; port 12 meters 5,6
// - port 14 serial2 with segment 33-35 selectors
`timescale 1ns/100ps
`default_nettype none
module pmx_mux (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cfg_ready_in,
  input wire logic standby_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] port_latch_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] port_dir_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] port_sel_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] pin_level_in,
  input wire pmx_pkg::pmx_alt_drive_t alt_drive_in,
  output logic [pmx_pkg::PMX_PINS-1:0] pin_value_out,
  output logic [pmx_pkg::PMX_PINS-1:0] pin_oe_out,
  output logic [pmx_pkg::PMX_PINS-1:0] port_read_out,
  output pmx_pkg::pmx_alt_sense_t alt_sense_out
);
  import pmx_pkg::*;

  // whole module state
  typedef struct packed {
    logic released; // set once port config is valid after reset
    logic [PMX_PINS-1:0] value;
    logic [PMX_PINS-1:0] oe;
    logic [PMX_PINS-1:0] level;
  } pmx_state_t;

  pmx_state_t r; // registered state
  pmx_state_t next_r; // next state
  logic [PMX_PINS-1:0] alt_comb; // peripheral values for and/or pins
  logic [PMX_PINS-1:0] alt_sel; // lcd / meter values for selector pins
  logic [PMX_PINS-1:0] cell_value; // per-pin combined value
  logic [PMX_PINS-1:0] cell_oe; // per-pin enable

  // peripheral outputs routed to their combining pins
  always_comb begin
    alt_comb = '0;
    alt_comb[P1+1] = alt_drive_in.serial0_data_out;
    alt_comb[P1+2] = alt_drive_in.serial0_clock_out;
    alt_comb[P1+4] = alt_drive_in.async_tx[0];
    alt_comb[P1+6] = alt_drive_in.async_tx[1];
    alt_comb[P2+4:P2+1] = alt_drive_in.timer_g_compare_out;
    alt_comb[P2+7:P2+6] = alt_drive_in.byte_timer_out;
    alt_comb[P3+0] = alt_drive_in.processor_clock_out;
    alt_comb[P3+1] = alt_drive_in.timer_c_out[0];
    alt_comb[P3+3] = alt_drive_in.timer_c_out[1];
    alt_comb[P8+1] = alt_drive_in.serial1_data_out;
    alt_comb[P8+2] = alt_drive_in.serial1_clock_out;
    alt_comb[P8+4] = alt_drive_in.can_tx_pin[0];
    alt_comb[P8+6] = alt_drive_in.can_tx_pin[1];
    alt_comb[P14+1] = alt_drive_in.serial2_data_out;
    alt_comb[P14+2] = alt_drive_in.serial2_clock_out;
  end

  // lcd and meter lines in order across selector ports
  always_comb begin
    alt_sel = '0;
    alt_sel[P4+3:P4] = alt_drive_in.lcd_common_out;
    alt_sel[P4+7:P4+4] = alt_drive_in.lcd_segment_out[3:0];
    alt_sel[P5+7:P5] = alt_drive_in.lcd_segment_out[11:4];
    alt_sel[P6+5:P6] = alt_drive_in.lcd_segment_out[17:12];
    alt_sel[P9+6:P9] = alt_drive_in.lcd_segment_out[24:18];
    alt_sel[P10+7:P10] = alt_drive_in.meter_drive_out[7:0];
    alt_sel[P11+7:P11] = alt_drive_in.meter_drive_out[15:8];
    alt_sel[P12+7:P12] = alt_drive_in.meter_drive_out[23:16];
    alt_sel[P13+7:P13] = alt_drive_in.lcd_segment_out[32:25];
    alt_sel[P14+2:P14] = alt_drive_in.lcd_segment_out[35:33];
  end

  // one cell per pin; scheme fixed by the package masks
  genvar gi;
  generate
    for (gi = 0; gi < PMX_PINS; gi++) begin : g_pin
      pmx_pin_cell #(
        .IS_AND(PMX_AND_MASK[gi]),
        .IS_OR(PMX_OR_MASK[gi]),
        .IS_SEL(PMX_SEL_MASK[gi]),
        .OUT_ONLY(PMX_OUT_MASK[gi]),
        .IN_ONLY(PMX_IN_MASK[gi])
      ) u_cell (
        .port_bit_in(port_latch_in[gi]),
        .dir_out_in(port_dir_in[gi]),
        .sel_alt_in(port_sel_in[gi]),
        .alt_comb_in(alt_comb[gi]),
        .alt_sel_in(alt_sel[gi]),
        .value_out(cell_value[gi]),
        .oe_out(cell_oe[gi])
      );
    end
  endgenerate

  // next state: hold in standby, hi-z until configuration is ready
  always_comb begin
    next_r = r;
    next_r.level = pin_level_in;
    if (cfg_ready_in) begin
      next_r.released = 1'b1;
    end
    if (standby_in) begin
      // pins keep their state; a dominant can level stays too
      next_r.value = r.value;
      next_r.oe = r.oe;
    end else if (!r.released) begin
      next_r.value = '0;
      next_r.oe = '0;
    end else begin
      next_r.value = cell_value;
      next_r.oe = cell_oe;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '{released: 1'b0, value: PMX_PIN_RST, oe: PMX_PIN_RST, level: PMX_PIN_RST};
    end else begin
      r <= next_r;
    end
  end

  assign pin_value_out = r.value;
  assign pin_oe_out = r.oe;
  assign port_read_out = r.level;

  // shared inputs fan out straight from the sampled pin levels
  always_comb begin
    alt_sense_out.nmi = r.level[P0];
    alt_sense_out.ext_irq_in[3:0] = r.level[P0+4:P0+1];
    alt_sense_out.ext_irq_in[4] = r.level[P1+3];
    alt_sense_out.ext_irq_in[5] = r.level[P1+5];
    alt_sense_out.serial0_data_in = r.level[P1+0];
    alt_sense_out.serial0_clock_in = r.level[P1+2];
    alt_sense_out.async_rx = {r.level[P1+5], r.level[P1+3]};
    alt_sense_out.timer_g_capture_in = r.level[P2+5:P2];
    alt_sense_out.byte_timer_count_in = r.level[P2+7:P2+6];
    alt_sense_out.timer_c_capture_in = r.level[P3+4:P3+1];
    alt_sense_out.serial1_data_in = r.level[P8+0];
    alt_sense_out.serial1_clock_in = r.level[P8+2];
    alt_sense_out.can_rx_pin = {r.level[P8+5], r.level[P8+3]};
    alt_sense_out.analog_channel_in = r.level[P7+7:P7];
    alt_sense_out.serial2_data_in = r.level[P14+0];
    alt_sense_out.serial2_clock_in = r.level[P14+2];
  end

  // checks below pause while reset is high
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // reset check and the mid-run reset cover stay armed through reset itself, unlike the rest
  a_reset_hiz: assert property (@(posedge clk_in) disable iff (1'b0)
      rst_in |=> (pin_oe_out == '0) && (pin_value_out == '0) && (port_read_out == '0))
    else $error("pins not hi-z after reset");
  a_unreleased_hiz: assert property (!r.released |-> (pin_oe_out == '0))
    else $error("pin driven before configuration ready");
  // a dominant can level frozen here is software's problem, not ours
  a_standby_hold: assert property (standby_in
      |=> $stable(pin_value_out) && $stable(pin_oe_out))
    else $error("pin changed in standby");
  a_and_pin: assert property (r.released && !standby_in && !port_sel_in[P1+4]
      |=> pin_value_out[P1+4] == ($past(port_latch_in[P1+4]) & $past(alt_drive_in.async_tx[0]))
      && pin_oe_out[P1+4] == $past(port_dir_in[P1+4]))
    else $error("and pin wrong");
  a_or_pin: assert property (r.released && !standby_in
      |=> pin_value_out[P2+1] == ($past(port_latch_in[P2+1])
      | $past(alt_drive_in.timer_g_compare_out[0])))
    else $error("or pin wrong");
  a_sel_common: assert property (r.released && !standby_in && port_sel_in[P4]
      |=> pin_oe_out[P4] && pin_value_out[P4] == $past(alt_drive_in.lcd_common_out[0]))
    else $error("lcd common not selected");
  a_seg35_sel: assert property (r.released && !standby_in && port_sel_in[P14+2]
      |=> pin_value_out[P14+2] == $past(alt_drive_in.lcd_segment_out[35]))
    else $error("segment 35 not selected");
  a_segment_last: assert property (r.released && !standby_in && port_sel_in[P13+7]
      |=> pin_oe_out[P13+7] && pin_value_out[P13+7] == $past(alt_drive_in.lcd_segment_out[32]))
    else $error("segment 32 not selected");
  a_meter_sel: assert property (r.released && !standby_in && port_sel_in[P12]
      |=> pin_oe_out[P12] && pin_value_out[P12] == $past(alt_drive_in.meter_drive_out[16]))
    else $error("meter channel 5 not selected");
  a_share_irq: assert property (1'b1
      |=> alt_sense_out.ext_irq_in[0] == $past(pin_level_in[P0+1])
      && port_read_out[P0+1] == $past(pin_level_in[P0+1]))
    else $error("shared irq input wrong");
  a_nmi_share: assert property (1'b1
      |=> alt_sense_out.nmi == $past(pin_level_in[P0]))
    else $error("nmi input not shared");
  a_rx_share: assert property (1'b1
      |=> alt_sense_out.async_rx[1] == $past(pin_level_in[P1+5])
      && alt_sense_out.ext_irq_in[5] == $past(pin_level_in[P1+5]))
    else $error("receive input not shared");
  a_can_rx_share: assert property (1'b1
      |=> alt_sense_out.can_rx_pin[0] == $past(pin_level_in[P8+3]))
    else $error("can receive not shared");
  a_input_only: assert property (pin_oe_out[P7+7:P7] == 8'h00)
    else $error("input-only port driven");
  a_out_only: assert property (r.released && !standby_in
      |=> pin_oe_out[P11+7:P10] == 16'hffff)
    else $error("output-only port not driven");
  a_plain_bit: assert property (r.released && !standby_in
      |=> pin_value_out[P3+5] == $past(port_latch_in[P3+5])
      && pin_oe_out[P3+5] == $past(port_dir_in[P3+5]))
    else $error("plain port bit wrong");
  a_dir_enable: assert property (r.released && !standby_in
      |=> pin_oe_out[P8+4] == $past(port_dir_in[P8+4]))
    else $error("combined pin enable not from direction");

  // main scenarios: release, standby round trip, selector, and-pin drive, mid-run reset
  c_release: cover property (!r.released ##1 r.released);
  c_standby: cover property (r.released && standby_in [*3] ##1 !standby_in);
  c_select_seg: cover property (r.released && port_sel_in[P5] ##1 pin_oe_out[P5]);
  c_and_drive: cover property (r.released && !standby_in && port_dir_in[P1+4]
      ##1 pin_oe_out[P1+4]);
  c_reset_again: cover property (@(posedge clk_in) disable iff (1'b0) r.released ##1 rst_in);
endmodule : pmx_mux
`default_nettype wire

// file: hdl/pmx_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
// one pin's combining scheme; purely combinational, registered by the top
module pmx_pin_cell #(
  parameter bit IS_AND = 1'b0,
  parameter bit IS_OR = 1'b0,
  parameter bit IS_SEL = 1'b0,
  parameter bit OUT_ONLY = 1'b0,
  parameter bit IN_ONLY = 1'b0
) (
  input wire logic port_bit_in,
  input wire logic dir_out_in,
  input wire logic sel_alt_in,
  input wire logic alt_comb_in,
  input wire logic alt_sel_in,
  output logic value_out,
  output logic oe_out
);
  // combine, then let the selector override
  always_comb begin
    value_out = port_bit_in;
    oe_out = dir_out_in | OUT_ONLY;
    if (IS_AND) begin
      value_out = port_bit_in & alt_comb_in;
    end else if (IS_OR) begin
      value_out = port_bit_in | alt_comb_in;
    end
    if (IS_SEL && sel_alt_in) begin
      // alternate line is an output driver, so it owns the pin
      value_out = alt_sel_in;
      oe_out = 1'b1;
    end
    if (IN_ONLY) begin
      oe_out = 1'b0;
    end
  end
endmodule : pmx_pin_cell
`default_nettype wire

// file: hdl/pmx_pkg.sv
package pmx_pkg;
  // total pins across ports 0 to 14, laid out port 0 first, lsb first
  localparam int PMX_PINS = 107;
  // base index of each port inside the flat pin vector
  localparam int P0 = 0;
  localparam int P1 = 5;
  localparam int P2 = 12;
  localparam int P3 = 20;
  localparam int P4 = 26;
  localparam int P5 = 34;
  localparam int P6 = 42;
  localparam int P7 = 48;
  localparam int P8 = 56;
  localparam int P9 = 64;
  localparam int P10 = 71;
  localparam int P11 = 79;
  localparam int P12 = 87;
  localparam int P13 = 95;
  localparam int P14 = 103;
  // lcd / meter line counts
  localparam int PMX_SEGS = 36;
  localparam int PMX_METER = 24;

  // concatenation order: port 14 down to port 0, port widths 4,8,8,8,8,7,8,8,6,8,8,6,8,7,5
  // and-combined pins
  localparam logic [PMX_PINS-1:0] PMX_AND_MASK = {4'h4, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00,
    8'h54, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 8'h00, 7'h54, 5'h00};
  // or-combined pins
  localparam logic [PMX_PINS-1:0] PMX_OR_MASK = {4'h2, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00,
    8'h02, 8'h00, 6'h00, 8'h00, 8'h00, 6'h0b, 8'hde, 7'h02, 5'h00};
  // pins with a hardware selector to an lcd or meter line
  localparam logic [PMX_PINS-1:0] PMX_SEL_MASK = {4'h7, 8'hff, 8'hff, 8'hff, 8'hff, 7'h7f,
    8'h00, 8'h00, 6'h3f, 8'hff, 8'hff, 6'h00, 8'h00, 7'h00, 5'h00};
  // output-only pins (ports 10 and 11)
  localparam logic [PMX_PINS-1:0] PMX_OUT_MASK = {4'h0, 8'h00, 8'h00, 8'hff, 8'hff, 7'h00,
    8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 8'h00, 7'h00, 5'h00};
  // input-only pins (port 7)
  localparam logic [PMX_PINS-1:0] PMX_IN_MASK = {4'h0, 8'h00, 8'h00, 8'h00, 8'h00, 7'h00,
    8'h00, 8'hff, 6'h00, 8'h00, 8'h00, 6'h00, 8'h00, 7'h00, 5'h00};
  // flop reset values
  localparam logic [PMX_PINS-1:0] PMX_PIN_RST = '0;

  // outputs that peripherals offer to the pins
  typedef struct packed {
    logic serial0_data_out;
    logic serial0_clock_out;
    logic [1:0] async_tx;
    logic [3:0] timer_g_compare_out;
    logic [1:0] byte_timer_out;
    logic processor_clock_out;
    logic [1:0] timer_c_out;
    logic serial1_data_out;
    logic serial1_clock_out;
    logic [1:0] can_tx_pin;
    logic serial2_data_out;
    logic serial2_clock_out;
    logic [3:0] lcd_common_out;
    logic [PMX_SEGS-1:0] lcd_segment_out;
    logic [PMX_METER-1:0] meter_drive_out;
  } pmx_alt_drive_t;

  // pin levels handed to peripherals
  typedef struct packed {
    logic nmi;
    logic [5:0] ext_irq_in;
    logic serial0_data_in;
    logic serial0_clock_in;
    logic [1:0] async_rx;
    logic [5:0] timer_g_capture_in;
    logic [1:0] byte_timer_count_in;
    logic [3:0] timer_c_capture_in;
    logic serial1_data_in;
    logic serial1_clock_in;
    logic [1:0] can_rx_pin;
    logic [7:0] analog_channel_in;
    logic serial2_data_in;
    logic serial2_clock_in;
  } pmx_alt_sense_t;
endpackage : pmx_pkg

// file: sim/pmx_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pmx_mux_tb;
  import pmx_pkg::*;
  typedef logic [PMX_PINS-1:0] pmx_vec_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cfg_ready_in = 1'b0;
  logic standby_in = 1'b0;
  pmx_vec_t latch = '0, dir = '0, sel = '0, ext = '0;
  pmx_alt_drive_t alt = '0;
  pmx_vec_t pin_level, pin_value, pin_oe, port_read;
  pmx_alt_sense_t sense;
  pmx_vec_t am = '0, om = '0, sm = '0, im = '0, qm = '0; // scheme masks
  pmx_vec_t exp_v, exp_oe, cv_s, lvl_s; // expectations, sampled pad level
  int and_pins[7] = '{P1+2, P1+4, P1+6, P8+2, P8+4, P8+6, P14+2};
  int or_pins[12] = '{P1+1, P2+1, P2+2, P2+3, P2+4, P2+6, P2+7, P3, P3+1, P3+3, P8+1, P14+1};
  int miscompares = 0;
  int checks_done = 0;

  always #5 clk_in = ~clk_in;

  pmx_mux pmx_mux_inst (.clk_in(clk_in), .rst_in(rst_in), .cfg_ready_in(cfg_ready_in),
    .standby_in(standby_in), .port_latch_in(latch), .port_dir_in(dir), .port_sel_in(sel),
    .pin_level_in(pin_level), .alt_drive_in(alt), .pin_value_out(pin_value),
    .pin_oe_out(pin_oe), .port_read_out(port_read), .alt_sense_out(sense));
  pmx_pad_model pmx_pad_model_inst (.pin_value_in(pin_value), .pin_oe_in(pin_oe),
    .ext_level_in(ext), .pin_level_out(pin_level));

  function automatic pmx_vec_t rnd();
    logic [127:0] r;
    r = {$urandom, $urandom, $urandom, $urandom};
    return r[PMX_PINS-1:0];
  endfunction : rnd
  // peripheral outputs placed on their combined pins
  function automatic pmx_vec_t comb(pmx_alt_drive_t d);
    pmx_vec_t c;
    c = '0;
    c[P1+1] = d.serial0_data_out;
    c[P1+2] = d.serial0_clock_out;
    c[P1+4] = d.async_tx[0];
    c[P1+6] = d.async_tx[1];
    c[P2+4:P2+1] = d.timer_g_compare_out;
    c[P2+7:P2+6] = d.byte_timer_out;
    c[P3] = d.processor_clock_out;
    c[P3+1] = d.timer_c_out[0];
    c[P3+3] = d.timer_c_out[1];
    c[P8+1] = d.serial1_data_out;
    c[P8+2] = d.serial1_clock_out;
    c[P8+4] = d.can_tx_pin[0];
    c[P8+6] = d.can_tx_pin[1];
    c[P14+1] = d.serial2_data_out;
    c[P14+2] = d.serial2_clock_out;
    return c;
  endfunction : comb
  // lcd and meter lines placed on their selector pins
  function automatic pmx_vec_t selv(pmx_alt_drive_t d);
    pmx_vec_t s;
    s = '0;
    s[P4+7:P4] = {d.lcd_segment_out[3:0], d.lcd_common_out};
    s[P5+7:P5] = d.lcd_segment_out[11:4];
    s[P6+5:P6] = d.lcd_segment_out[17:12];
    s[P9+6:P9] = d.lcd_segment_out[24:18];
    s[P13+7:P13] = d.lcd_segment_out[32:25];
    s[P14+2:P14] = d.lcd_segment_out[35:33];
    s[P12+7:P10] = d.meter_drive_out;
    return s;
  endfunction : selv
  // pad levels as each peripheral input should see them
  function automatic pmx_alt_sense_t sns(pmx_vec_t l);
    pmx_alt_sense_t s;
    s.nmi = l[P0];
    s.ext_irq_in = {l[P1+5], l[P1+3], l[P0+4:P0+1]};
    s.serial0_data_in = l[P1];
    s.serial0_clock_in = l[P1+2];
    s.async_rx = {l[P1+5], l[P1+3]};
    s.timer_g_capture_in = l[P2+5:P2];
    s.byte_timer_count_in = l[P2+7:P2+6];
    s.timer_c_capture_in = l[P3+4:P3+1];
    s.serial1_data_in = l[P8];
    s.serial1_clock_in = l[P8+2];
    s.can_rx_pin = {l[P8+5], l[P8+3]};
    s.analog_channel_in = l[P7+7:P7];
    s.serial2_data_in = l[P14];
    s.serial2_clock_in = l[P14+2];
    return s;
  endfunction : sns

  task automatic chk(input string nm, input pmx_vec_t e, input pmx_vec_t g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // fresh random port settings, peripheral outputs and board levels
  task automatic shake();
    pmx_vec_t v;
    v = rnd();
    latch = rnd();
    dir = rnd();
    sel = rnd();
    ext = rnd();
    alt = v[$bits(pmx_alt_drive_t)-1:0];
  endtask : shake
  // expectation at the negedge, one edge later compare
  task automatic step(input bit c);
    pmx_vec_t cv, sa, v;
    @(negedge clk_in);
    cv = comb(alt);
    sa = sel & sm;
    v = (latch & ~(am | om)) | (am & latch & cv) | (om & (latch | cv));
    if (!standby_in) begin // standby keeps the last pin state
      exp_v = (sa & selv(alt)) | (~sa & v);
      exp_oe = ~im & (qm | sa | dir);
      cv_s = cv;
    end
    lvl_s = pin_level;
    @(posedge clk_in);
    #1;
    if (c) begin
      chk("pin_oe", exp_oe, pin_oe);
      chk("pin_value", exp_v & exp_oe, pin_value & exp_oe);
      chk("port_read", lvl_s, port_read);
      chk("alt_sense", PMX_PINS'(sns(lvl_s)), PMX_PINS'(sense));
    end
  endtask : step

  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end

  initial begin
    void'($urandom(54399));
    foreach (and_pins[i]) am[and_pins[i]] = 1'b1;
    foreach (or_pins[i]) om[or_pins[i]] = 1'b1;
    for (int i = P4; i < P7; i++) sm[i] = 1'b1;
    for (int i = P9; i < P14 + 3; i++) sm[i] = 1'b1;
    for (int i = P7; i < P8; i++) im[i] = 1'b1;
    for (int i = P10; i < P12; i++) qm[i] = 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    shake();
    // not yet configured: pads must stay undriven
    repeat (3) begin
      @(posedge clk_in);
      #1;
      chk("oe_after_reset", '0, pin_oe);
    end
    cfg_ready_in = 1'b1;
    step(0);
    repeat (60) begin
      shake();
      step(1);
    end
    // software holds and-pins at one, or-pins at zero: peripheral alone
    repeat (8) begin
      shake();
      latch = am | (latch & ~om);
      dir = dir | am | om;
      sel = '0;
      step(1);
      chk("comb_alone", cv_s & (am | om), pin_value & (am | om));
    end
    // can transmit parked recessive before standby, then pins frozen
    latch[P8+4] = 1'b1;
    latch[P8+6] = 1'b1;
    alt.can_tx_pin = 2'b11;
    step(1);
    standby_in = 1'b1;
    repeat (4) begin
      shake();
      step(1);
    end
    standby_in = 1'b0;
    step(1);
    // second reset in mid-run
    shake();
    rst_in = 1'b1;
    @(posedge clk_in);
    #1;
    chk("oe_in_reset", '0, pin_oe);
    chk("read_in_reset", '0, port_read);
    rst_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("oe_released", '0, pin_oe);
    repeat (20) begin
      shake();
      step(1);
    end
    wrap_up();
  end
endmodule : pmx_mux_tb
`default_nettype wire

// file: sim/pmx_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
// board side of the pads: a driven pad shows the block's value,
// an undriven pad shows whatever the board puts on it this cycle
module pmx_pad_model (
  input wire logic [pmx_pkg::PMX_PINS-1:0] pin_value_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] pin_oe_in,
  input wire logic [pmx_pkg::PMX_PINS-1:0] ext_level_in,
  output logic [pmx_pkg::PMX_PINS-1:0] pin_level_out
);
  import pmx_pkg::*;
  // board backs off where the block drives; no contention modelled
  always_comb begin
    pin_level_out = (pin_oe_in & pin_value_in) | (~pin_oe_in & ext_level_in);
  end
endmodule : pmx_pad_model
`default_nettype wire
